// File: logic/tmr_pkg.sv
// package for the sixteen-bit timer/counter: register map, field positions, reset values
// assumes a byte-wide register port and a single core clock
package tmr_pkg;
  localparam int unsigned ADDR_W        = 8;
  localparam logic [7:0]  ADDR_CNT_LO   = 8'h0e;
  localparam logic [7:0]  ADDR_CNT_HI   = 8'h0f;
  localparam logic [7:0]  ADDR_CTRL     = 8'h10;
  localparam logic [7:0]  ADDR_FLAG     = 8'h0c;
  localparam logic [7:0]  ADDR_IRQ_EN   = 8'h8c;
  localparam logic [7:0]  CTRL_RESET    = 8'h00;
  localparam logic [7:0]  CTRL_MASK     = 8'h3f;
  localparam int unsigned BIT_ON        = 0;
  localparam int unsigned BIT_CS        = 1;
  localparam int unsigned BIT_SYNC_DIS  = 2;
  localparam int unsigned BIT_OSC_EN    = 3;
  localparam int unsigned BIT_PS_LO     = 4;
  localparam int unsigned BIT_OVF       = 0;
  localparam int unsigned PS_W          = 2;
  localparam int unsigned PS_CNT_W      = 3;
  localparam logic [1:0]  QCNT_LAST     = 2'h3;
  localparam logic [1:0]  Q2_PHASE      = 2'h1;
  localparam logic [1:0]  Q4_PHASE      = 2'h3;
  localparam int unsigned INC_DELAY     = 2;

  typedef struct packed {
    logic [1:0] prescale_select;
    logic       low_power_osc_enable;
    logic       sync_disable_bit;
    logic       clock_source_select;
    logic       timer_on;
  } ctrl_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata;
    logic              wr;
    logic              rd;
  } bus_req_s;
endpackage

// File: logic/tmr_prescaler.sv
// prescaler fed by the chosen external edge source
// assumes the source has been brought into the clk_i domain by the caller
module tmr_prescaler
  import tmr_pkg::*;
#(
  parameter int unsigned CNT_W = PS_CNT_W
) (
  input  wire logic            clk_i,
  input  wire logic            rst_i,
  input  wire logic            clear_i,
  input  wire logic [PS_W-1:0] select_i,
  input  wire logic            src_i,
  output logic                 out_o
);
  logic [CNT_W-1:0] div_q;
  logic             src_q;

  // a counter per rising edge; bit n toggles symmetrically, like a ripple stage
  always_ff @(posedge clk_i) begin
    if (rst_i || clear_i) begin
      div_q <= '0;
    end else if (src_i && !src_q) begin
      div_q <= div_q + CNT_W'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      src_q <= 1'b0;
    end else begin
      src_q <= src_i;
    end
  end

  always_comb begin
    case (select_i)
      2'h0:    out_o = src_i;
      2'h1:    out_o = div_q[0];
      2'h2:    out_o = div_q[1];
      default: out_o = div_q[2];
    endcase
  end
endmodule // tmr_prescaler

// File: logic/tmr_phase_sync.sv
// samples the prescaler output on two quarter phases and flags a rising edge
// assumes the input is already metastability-safe in the clk_i domain
module tmr_phase_sync
  import tmr_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic enable_i,
  input  wire logic in_i,
  output logic      rise_o
);
  logic [1:0] phase_q;
  logic       samp_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_q <= '0;
    end else begin
      phase_q <= (phase_q == QCNT_LAST) ? 2'h0 : phase_q + 2'h1;
    end
  end

  // sampling only on q2 and q4 sets the min high and low time on the pin
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      samp_q <= 1'b0;
      rise_o <= 1'b0;
    end else begin
      rise_o <= 1'b0;
      if (enable_i && (phase_q == Q2_PHASE || phase_q == Q4_PHASE)) begin
        samp_q <= in_i;
        rise_o <= in_i && !samp_q;
      end
    end
  end
endmodule // tmr_phase_sync

// File: logic/timer_counter.sv
// sixteen-bit timer/counter with prescaler, overflow flag and enable
// assumes a single-cycle register port on clk_i (25 MHz) and async pins
//
// Overview of operation
// - sixteen-bit count in two bytes, wraps
// - overflow sets sticky flag until software clears
// - interrupt request only while enable set
// - source bit clear counts instruction cycles
// - timer mode ignores sync control bit
// - counter mode: osc pin or clock pin
// - counts only while timer on set
// - compare unit input resets the count
// - osc enable forces both pins input
// - sync after prescaler when sync bit clear
// - synced mode in sleep: no increment
// - sample prescaler on second, fourth quarters
// - one to one passes input straight
// - other ratios divide with symmetric output
// - increment applied fixed delay after detection
// - power-on reset clears control; others keep
// - writing either count byte clears prescaler
// - async counter mode runs in sleep
module timer_counter
  import tmr_pkg::*;
#(
  parameter int unsigned CNT_W = 16
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              por_i,
  input  wire logic              sleep_i,
  input  wire logic              compare_reset_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [7:0]        wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [7:0]        rdata_o,
  input  wire logic              osc_input_pin_i,
  input  wire logic              external_clock_pin_i,
  input  wire logic [1:0]        port_direction_bits_i,
  output logic      [1:0]        pin_oe_o,
  output logic                   irq_o,
  output logic                   overflow_flag_o
);
  bus_req_s         req;
  ctrl_s            ctrl_q;
  logic [CNT_W-1:0] count_q;
  logic             flag_q;
  logic             irq_en_q;
  logic [1:0]       osc_meta_q;
  logic [1:0]       ext_meta_q;
  logic             edge_src;
  logic             ps_out;
  logic             sync_rise;
  logic             async_rise;
  logic             ps_q;
  logic [INC_DELAY-1:0] inc_pipe_q;
  logic             inc_now;
  logic             inc_gate;
  logic             cnt_wr;
  logic             wrap;
  logic [1:0]       quarter_q;
  logic             instr_tick;

  assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

  // two-flop synchronisers for both pins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc_meta_q <= '0;
      ext_meta_q <= '0;
    end else begin
      osc_meta_q <= {osc_meta_q[0], osc_input_pin_i};
      ext_meta_q <= {ext_meta_q[0], external_clock_pin_i};
    end
  end

  assign edge_src = ctrl_q.low_power_osc_enable ? osc_meta_q[1] : ext_meta_q[1];
  assign cnt_wr   = req.wr && (req.addr == ADDR_CNT_LO || req.addr == ADDR_CNT_HI);

  tmr_prescaler #(
    .CNT_W (PS_CNT_W)
  ) u_ps (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .clear_i  (cnt_wr),
    .select_i (ctrl_q.prescale_select),
    .src_i    (edge_src),
    .out_o    (ps_out)
  );

  // prescaler keeps running in sleep; only the synchroniser is gated
  tmr_phase_sync u_sync (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .enable_i (!sleep_i),
    .in_i     (ps_out),
    .rise_o   (sync_rise)
  );

  // async mode takes the prescaler edge without phase sampling, also in sleep
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ps_q <= 1'b0;
    end else begin
      ps_q <= ps_out;
    end
  end
  assign async_rise = ps_out && !ps_q;

  // instruction cycle is four core clocks
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      quarter_q <= '0;
    end else begin
      quarter_q <= (quarter_q == QCNT_LAST) ? 2'h0 : quarter_q + 2'h1;
    end
  end
  assign instr_tick = (quarter_q == QCNT_LAST) && !sleep_i;

  always_comb begin
    if (!ctrl_q.clock_source_select) begin
      inc_gate = instr_tick;
    end else if (ctrl_q.sync_disable_bit) begin
      inc_gate = async_rise;
    end else begin
      inc_gate = sync_rise;
    end
  end

  // increment lands a fixed delay after the edge is seen
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      inc_pipe_q <= '0;
    end else begin
      inc_pipe_q <= {inc_pipe_q[INC_DELAY-2:0], inc_gate && ctrl_q.timer_on};
    end
  end
  assign inc_now = inc_pipe_q[INC_DELAY-1] && ctrl_q.timer_on;
  assign wrap    = inc_now && (count_q == '1) && !cnt_wr && !compare_reset_i;

  // count is not cleared by rst_i: it keeps its value through device resets
  always_ff @(posedge clk_i) begin
    if (req.wr && req.addr == ADDR_CNT_LO) begin
      count_q[7:0] <= req.wdata;
    end else if (req.wr && req.addr == ADDR_CNT_HI) begin
      count_q[CNT_W-1:8] <= req.wdata;
    end else if (compare_reset_i) begin
      count_q <= '0;
    end else if (inc_now) begin
      count_q <= count_q + CNT_W'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (por_i) begin
      ctrl_q <= ctrl_s'(CTRL_RESET[5:0]);
    end else if (req.wr && req.addr == ADDR_CTRL) begin
      ctrl_q <= ctrl_s'(req.wdata[5:0] & CTRL_MASK[5:0]);
    end
  end

  // set wins over a coinciding software clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_q <= 1'b0;
    end else if (wrap) begin
      flag_q <= 1'b1;
    end else if (req.wr && req.addr == ADDR_FLAG) begin
      flag_q <= req.wdata[BIT_OVF];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_en_q <= 1'b0;
    end else if (req.wr && req.addr == ADDR_IRQ_EN) begin
      irq_en_q <= req.wdata[BIT_OVF];
    end
  end

  assign irq_o           = flag_q && irq_en_q;
  assign overflow_flag_o = flag_q;
  assign pin_oe_o = ctrl_q.low_power_osc_enable ? 2'h0 : ~port_direction_bits_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o <= '0;
    end else if (req.rd) begin
      case (req.addr)
        ADDR_CNT_LO: rdata_o <= count_q[7:0];
        ADDR_CNT_HI: rdata_o <= count_q[CNT_W-1:8];
        ADDR_CTRL:   rdata_o <= {2'h0, ctrl_q};
        ADDR_FLAG:   rdata_o <= {7'h00, flag_q};
        ADDR_IRQ_EN: rdata_o <= {7'h00, irq_en_q};
        default:     rdata_o <= '0;
      endcase
    end else begin
      rdata_o <= '0;
    end
  end
endmodule // timer_counter

// File: tb/tmr_properties.sv
// checker for register port, flag, interrupt and pin enables of the timer/counter
// assumes it is bound to timer_counter and sees only that module's ports
module tmr_properties
  import tmr_pkg::*;
(
  input wire logic              clk_i,
  input wire logic              rst_i,
  input wire logic              por_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [7:0]        wdata_i,
  input wire logic              wr_i,
  input wire logic              rd_i,
  input wire logic [7:0]        rdata_o,
  input wire logic [1:0]        port_direction_bits_i,
  input wire logic [1:0]        pin_oe_o,
  input wire logic              irq_o,
  input wire logic              overflow_flag_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] ctrl_q;
  logic       en_q;
  // shadow copies follow the register port so outputs can be tied to writes
  always_ff @(posedge clk_i) begin
    if (por_i) ctrl_q <= CTRL_RESET;
    else if (wr_i && addr_i == ADDR_CTRL) ctrl_q <= wdata_i & CTRL_MASK;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) en_q <= 1'b0;
    else if (wr_i && addr_i == ADDR_IRQ_EN) en_q <= wdata_i[0];
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i || por_i);
  sequence rd_ctrl;
    rd_i && addr_i == ADDR_CTRL;
  endsequence
  // a raised flag that software leaves alone this cycle is still raised next cycle
  sequence flag_kept;
    overflow_flag_o && !(wr_i && addr_i == ADDR_FLAG);
  endsequence
  a_irq_gate: assert property (irq_o == (overflow_flag_o & en_q))
    else $error("irq does not follow flag and enable");
  a_pin_force: assert property (pin_oe_o == (ctrl_q[BIT_OSC_EN] ? 2'h0 : ~port_direction_bits_i))
    else $error("pin enables wrong");
  a_flag_hold: assert property (flag_kept |=> overflow_flag_o)
    else $error("flag dropped without a clear");
  a_ctrl_read: assert property (rd_ctrl |=> rdata_o == $past(ctrl_q))
    else $error("control read wrong");
  a_en_read: assert property (rd_i && addr_i == ADDR_IRQ_EN |=> rdata_o == {7'h00, $past(en_q)})
    else $error("enable read wrong");
  a_flag_read: assert property (rd_i && addr_i == ADDR_FLAG |=> rdata_o[0] == $past(overflow_flag_o))
    else $error("flag read wrong");
  a_unmapped_read: assert property (rd_i && addr_i == 8'h00 |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_idle: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("read data outside read");
endmodule // tmr_properties

// File: tb/tmr_clock_source.sv
// model of the external clock source and low-power crystal on the two pins
// assumes the bench calls burst; both pins rest low between bursts
module tmr_clock_source (
  input  wire logic clk_i,
  output logic      osc_pin_o,
  output logic      ext_pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    osc_pin_o = 1'b0;
    ext_pin_o = 1'b0;
  end
  // eight core cycles high and low keeps well clear of the sampling limit
  task automatic burst(input int n, input logic osc);
    repeat (n) begin
      repeat (8) @(posedge clk_i);
      if (osc) osc_pin_o <= 1'b1;
      else ext_pin_o <= 1'b1;
      repeat (8) @(posedge clk_i);
      osc_pin_o <= 1'b0;
      ext_pin_o <= 1'b0;
    end
  endtask
endmodule // tmr_clock_source

// File: tb/test_timer_counter.sv
// self-checking bench for timer_counter over its register port
// assumes the clock source model drives both pins; counts are loaded before use
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
  $display("unexpected %s expected %h seen %h", n, e, g); end end
module test_timer_counter;
  timeunit 1ns;
  timeprecision 1ps;
  import tmr_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, por_i = 1'b1, sleep_i = 1'b0, compare_reset_i = 1'b0;
  logic wr_i = 1'b0, rd_i = 1'b0;
  logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o, d;
  logic [1:0] port_direction_bits_i = 2'h1, pin_oe_o;
  logic       osc_pin, ext_pin, irq_o, overflow_flag_o;
  int         num_errors = 0, checks_done = 0;
  always #20 clk_i = ~clk_i;
  tmr_clock_source src (.clk_i(clk_i), .osc_pin_o(osc_pin), .ext_pin_o(ext_pin));
  timer_counter uut (.clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .sleep_i(sleep_i),
    .compare_reset_i(compare_reset_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .osc_input_pin_i(osc_pin), .external_clock_pin_i(ext_pin),
    .port_direction_bits_i(port_direction_bits_i), .pin_oe_o(pin_oe_o), .irq_o(irq_o),
    .overflow_flag_o(overflow_flag_o));
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask
  task automatic expect_cnt(input logic [15:0] e);
    logic [7:0] v;
    rd(ADDR_CNT_LO, v);
    `CHK("count_low", e[7:0], v)
    rd(ADDR_CNT_HI, v);
    `CHK("count_high", e[15:8], v)
  endtask
  task automatic zero_cnt;
    wr(ADDR_CNT_LO, 8'h00);
    wr(ADDR_CNT_HI, 8'h00);
  endtask
  task results;
    if (num_errors == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    results;
  end
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    por_i <= 1'b0;
    rd(ADDR_CTRL, d);
    `CHK("ctrl_por", 8'h00, d)
    wr(ADDR_CTRL, 8'hff);
    rd(ADDR_CTRL, d);
    `CHK("ctrl_rw", 8'h3f, d)
    `CHK("pin_oe_osc", 2'h0, pin_oe_o)
    @(posedge clk_i);
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    rd(ADDR_CTRL, d);
    `CHK("ctrl_kept", 8'h3f, d)
    wr(ADDR_CTRL, 8'h00);
    `CHK("pin_oe_dir", 2'h2, pin_oe_o)
    @(posedge clk_i);
    port_direction_bits_i <= 2'h2;
    @(posedge clk_i);
    `CHK("pin_oe_swap", 2'h1, pin_oe_o)
    rd(8'h00, d);
    `CHK("unmapped", 8'h00, d)
    // start three counts below wrap and run well past it
    wr(ADDR_CNT_LO, 8'hfd);
    wr(ADDR_CNT_HI, 8'hff);
    wr(ADDR_CTRL, 8'h01);
    repeat (40) @(posedge clk_i);
    wr(ADDR_CTRL, 8'h00);
    rd(ADDR_CNT_HI, d);
    `CHK("wrap_high", 8'h00, d)
    `CHK("flag_set", 1'b1, overflow_flag_o)
    rd(ADDR_FLAG, d);
    `CHK("flag_reg", 8'h01, d)
    `CHK("irq_masked", 1'b0, irq_o)
    wr(ADDR_IRQ_EN, 8'h01);
    `CHK("irq_on", 1'b1, irq_o)
    rd(ADDR_IRQ_EN, d);
    `CHK("irq_en_reg", 8'h01, d)
    wr(ADDR_FLAG, 8'h00);
    `CHK("flag_clr", 1'b0, irq_o | overflow_flag_o)
    zero_cnt;
    wr(ADDR_CTRL, 8'h05);
    repeat (400) @(posedge clk_i);
    wr(ADDR_CTRL, 8'h00);
    rd(ADDR_CNT_LO, d);
    `CHK("rate", 1'b1, (d >= 8'h63 && d <= 8'h66))
    wr(ADDR_CNT_LO, 8'h55);
    wr(ADDR_CNT_HI, 8'h12);
    repeat (40) @(posedge clk_i);
    expect_cnt(16'h1255);
    @(posedge clk_i);
    compare_reset_i <= 1'b1;
    @(posedge clk_i);
    compare_reset_i <= 1'b0;
    expect_cnt(16'h0000);
    for (int p = 0; p < 4; p++) begin
      wr(ADDR_CTRL, {2'h0, p[1:0], 4'h3});
      zero_cnt;
      src.burst(16, 1'b0);
      repeat (12) @(posedge clk_i);
      expect_cnt(16'h0010 >> p);
    end
    // six edges leave the divide-by-eight stage past its high edge
    src.burst(6, 1'b0);
    zero_cnt;
    src.burst(4, 1'b0);
    repeat (12) @(posedge clk_i);
    expect_cnt(16'h0001);
    wr(ADDR_CTRL, 8'h0b);
    zero_cnt;
    src.burst(16, 1'b1);
    repeat (12) @(posedge clk_i);
    expect_cnt(16'h0010);
    wr(ADDR_CTRL, 8'h03);
    zero_cnt;
    @(posedge clk_i);
    sleep_i <= 1'b1;
    src.burst(8, 1'b0);
    repeat (12) @(posedge clk_i);
    expect_cnt(16'h0000);
    wr(ADDR_CTRL, 8'h07);
    src.burst(8, 1'b0);
    repeat (12) @(posedge clk_i);
    expect_cnt(16'h0008);
    results;
  end
endmodule // test_timer_counter
bind timer_counter tmr_properties chk (.clk_i(clk_i), .rst_i(rst_i), .por_i(por_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .port_direction_bits_i(port_direction_bits_i), .pin_oe_o(pin_oe_o), .irq_o(irq_o),
  .overflow_flag_o(overflow_flag_o));
